// ==== dv/wdt_cpu_model.sv ====
/* wdt_cpu_model: cpu side taking the watchdog request pulses.
   Assumes one-cycle pulses in the sys_clk_i domain; por_n_i is power-on reset. */
module wdt_cpu_model (
	input  wire logic sys_clk_i,
	input  wire logic por_n_i,
	input  wire logic nmi_req_i,
	input  wire logic rst_req_i,
	output logic      chip_rst_n_o,
	output int        nmi_depth_o,
	output int        rst_seen_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold;
	always @(posedge sys_clk_i) begin
		if (!por_n_i) begin
			nmi_depth_o <= 0;
			rst_seen_o <= 0;
			hold <= 0;
			chip_rst_n_o <= 1'b1;
		end else begin
			// no return modelled, so each entry nests
			if (nmi_req_i) nmi_depth_o <= nmi_depth_o + 1;
			if (rst_req_i) rst_seen_o <= rst_seen_o + 1;
			hold <= rst_req_i ? 4 : (hold > 0 ? hold - 1 : 0);
			chip_rst_n_o <= !(rst_req_i || hold > 1);
		end
	end
endmodule : wdt_cpu_model

// ==== dv/wdt_top_properties.sv ====
/* wdt_chk: port-level properties of wdt_top, bound into every instance.
   Assumes the single sys_clk_i domain and sight of the top ports only. */
module wdt_chk #(
	parameter int ADR_W = 14
) (
	input wire logic             sys_clk_i,
	input wire logic             rst_n_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic [3:0]       wb_sel_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic             low_clk_tick_i,
	input wire logic             base_prescale_select_i,
	input wire logic             slow_mode_i,
	input wire logic             low_power_i,
	input wire logic             nmi_req_o,
	input wire logic             chip_rst_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic [11:0] idx = wb_adr_i[ADR_W-1:2];
	property p_rd_cnt;
		req && !wb_we_i && idx == wdt_pkg::IDX_COUNTER |=> wb_ack_o && wb_dat_o[31:8] == 24'h000000;
	endproperty
	a_rd_cnt: assert property (p_rd_cnt) else $error("counter read badly answered");
	property p_rd_sta;
		req && !wb_we_i && idx == wdt_pkg::IDX_STATUS |=> wb_ack_o && wb_dat_o[7:3] == 5'h0B;
	endproperty
	a_rd_sta: assert property (p_rd_sta) else $error("status fixed bits wrong");
	property p_rd_code;
		req && !wb_we_i && idx == wdt_pkg::IDX_CODE |=> wb_ack_o && wb_dat_o == 32'h00000000;
	endproperty
	a_rd_code: assert property (p_rd_code) else $error("code port read not zero");
	property p_clr_wins;
		req && wb_we_i && wb_sel_i[0] && idx == wdt_pkg::IDX_CODE && wb_dat_i[7:0] == wdt_pkg::CODE_CLEAR
			|=> wb_ack_o ##1 !chip_rst_req_o;
	endproperty
	a_clr_wins: assert property (p_clr_wins) else $error("overflow beside clear");
	property p_frozen;
		low_power_i [*4] |-> !chip_rst_req_o;
	endproperty
	a_frozen: assert property (p_frozen) else $error("overflow while paused");
	property p_one_action;
		!(nmi_req_o && chip_rst_req_o);
	endproperty
	a_one_action: assert property (p_one_action) else $error("both overflow actions");
	property p_rst_gap;
		chip_rst_req_o |=> !chip_rst_req_o [*8];
	endproperty
	a_rst_gap: assert property (p_rst_gap) else $error("reset request repeated");
	property p_quiet_start;
		$rose(rst_n_i) |-> !chip_rst_req_o [*8];
	endproperty
	a_quiet_start: assert property (p_quiet_start) else $error("reset request after release");
endmodule : wdt_chk

bind wdt_top wdt_chk #(.ADR_W(ADR_W)) u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_clk_tick_i(low_clk_tick_i),
	.base_prescale_select_i(base_prescale_select_i), .slow_mode_i(slow_mode_i), .low_power_i(low_power_i),
	.nmi_req_o(nmi_req_o), .chip_rst_req_o(chip_rst_req_o));

// ==== dv/wdt_top_tb.sv ====
/* wdt_top_tb: scenario bench for the windowed watchdog.
   Assumes the cpu model and the bound checker; low clock ticks every cycle unless a scenario stops it. */
module wdt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] CTL = wdt_pkg::IDX_CONTROL;
	localparam logic [11:0] CDP = wdt_pkg::IDX_CODE;
	localparam logic [11:0] CNT = wdt_pkg::IDX_COUNTER;
	localparam logic [11:0] STA = wdt_pkg::IDX_STATUS;
	logic        clk = 1'b0;
	logic        por_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [13:0] adr = 14'h0000;
	logic [31:0] dat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic        lp = 1'b0;
	logic        lck = 1'b1;
	logic        base = 1'b1;
	logic        slow = 1'b0;
	logic [31:0] rdat, q, a, b;
	logic        ack, nmi, crst, cpu_n;
	int          depth, rsts, d, n;
	int          mismatches = 0;
	int          checks = 0;
	always #2.5 clk = ~clk;
	wdt_top #(.WARMUP_CYCLES(4)) dut (.sys_clk_i(clk), .rst_n_i(por_n && cpu_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.low_clk_tick_i(lck), .base_prescale_select_i(base), .slow_mode_i(slow), .low_power_i(lp),
		.nmi_req_o(nmi), .chip_rst_req_o(crst));
	wdt_cpu_model cpu (.sys_clk_i(clk), .por_n_i(por_n), .nmi_req_i(nmi), .rst_req_i(crst),
		.chip_rst_n_o(cpu_n), .nmi_depth_o(depth), .rst_seen_o(rsts));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic die();
		mismatches++;
		wrap_up();
	endtask : die
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// entered just after a rising edge; holds until ack is sampled
	task automatic wb(input logic w, input logic [11:0] i, input logic [7:0] v, output logic [31:0] r);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'h0};
		dat <= {24'h000000, v};
		sel <= 4'h1;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 50) die();
		@(posedge clk);
	endtask : wb
	task automatic wr(input logic [11:0] i, input logic [7:0] v);
		wb(1'b1, i, v, q);
	endtask : wr
	task automatic rd(input logic [11:0] i, output logic [31:0] r);
		wb(1'b0, i, 8'h00, r);
	endtask : rd
	task automatic wait_inc(ref int c, input int old);
		n = 0;
		while (c == old && n < 6000) begin
			@(posedge clk);
			n++;
		end
		if (c == old) die();
	endtask : wait_inc
	task automatic poll(input logic [7:0] v);
		q = 32'h0;
		for (int k = 0; q[7:0] < v; k++) begin
			if (k > 2000) die();
			rd(CNT, q);
		end
	endtask : poll
	task automatic t_reset();
		rd(STA, q); chk(q, 32'h59);
		rd(CTL, q); chk(q, 32'h81);
		rd(CDP, q); chk(q, 32'h0);
		rd(12'h001, q); chk(q, 32'h0);
	endtask : t_reset
	task automatic t_codes();
		rd(CNT, a);
		repeat (40) @(posedge clk);
		rd(CNT, b); chk({31'h0, (b - a) inside {32'h5, 32'h6}}, 32'h1);
		wr(CDP, 8'h55);
		rd(CNT, q); chk({31'h0, q >= b}, 32'h1);
		wr(CDP, wdt_pkg::CODE_CLEAR);
		rd(CNT, q); chk({31'h0, q <= 32'h1}, 32'h1);
	endtask : t_codes
	task automatic t_nmi();
		d = depth;
		wait_inc(depth, d); chk({31'h0, n inside {[2030:2056]}}, 32'h1);
		rd(STA, q); chk(q, 32'h5D);
		rd(STA, q); chk(q, 32'h59);
		rd(CNT, q); chk({31'h0, q inside {[32'h1:32'h3]}}, 32'h1);
	endtask : t_nmi
	task automatic t_window();
		wr(CDP, wdt_pkg::CODE_DISABLE);
		rd(STA, q); chk(q, 32'h59);
		wr(CTL, 8'h30);
		wr(CDP, wdt_pkg::CODE_DISABLE);
		rd(STA, q); chk(q, 32'h58);
		rd(CNT, q); chk(q, 32'h0);
		wr(CTL, 8'h31);
		wr(CTL, 8'h02);
		rd(CTL, q); chk(q, 32'hB0);
		wr(CTL, 8'h31);
		poll(8'h40);
		d = depth;
		wr(CDP, wdt_pkg::CODE_CLEAR);
		rd(STA, q); chk(q, 32'h5B);
		chk(depth, d + 1);
		rd(CNT, q); chk({31'h0, q >= 32'h40}, 32'h1);
		poll(8'hE0);
		wr(CDP, wdt_pkg::CODE_CLEAR);
		rd(CNT, q); chk({31'h0, q <= 32'h1}, 32'h1);
		chk(depth, d + 1);
	endtask : t_window
	task automatic t_low_power();
		lp <= 1'b1;
		rd(CNT, a);
		repeat (100) @(posedge clk);
		rd(CNT, b); chk(b, a);
		lp <= 1'b0;
		repeat (40) @(posedge clk);
		rd(CNT, b); chk({31'h0, b > a}, 32'h1);
	endtask : t_low_power
	task automatic t_rst_mode();
		wr(CTL, 8'h30);
		wr(CDP, wdt_pkg::CODE_DISABLE);
		wr(CTL, 8'h03);
		d = depth;
		wait_inc(rsts, rsts);
		chk(depth, d);
		repeat (20) @(posedge clk);
		rd(CTL, q); chk(q, 32'h81);
	endtask : t_rst_mode
	// gear source ticks 128 times slower than the low ticks, so it gets the long wait
	task automatic t_sources();
		base <= 1'b0;
		rd(CNT, a);
		repeat (2100) @(posedge clk);
		rd(CNT, b); chk({31'h0, (b - a) inside {32'h2, 32'h3}}, 32'h1);
		slow <= 1'b1;
		rd(CNT, a);
		repeat (40) @(posedge clk);
		rd(CNT, b); chk({31'h0, (b - a) inside {32'h5, 32'h6}}, 32'h1);
		lck <= 1'b0;
		rd(CNT, a);
		repeat (100) @(posedge clk);
		rd(CNT, b); chk(b, a);
		lck <= 1'b1;
		wr(CTL, 8'h00);
		wr(CDP, wdt_pkg::CODE_DISABLE);
		wr(CTL, 8'h05);
		rd(CNT, a);
		repeat (200) @(posedge clk);
		rd(CNT, b); chk({31'h0, (b - a) inside {32'h6, 32'h7}}, 32'h1);
	endtask : t_sources
	initial begin
		repeat (5) @(posedge clk);
		por_n <= 1'b1;
		repeat (10) @(posedge clk);
		t_reset();
		t_codes();
		t_nmi();
		t_window();
		t_low_power();
		t_rst_mode();
		t_sources();
		wrap_up();
	end
endmodule : wdt_top_tb

// ==== rtl/wdt_pkg.sv ====
/*
 * wdt_pkg: constants, register map and types for the windowed watchdog.
 * Assumes a 32-bit classic Wishbone slave port and a 200 MHz system clock that is also the gear clock.
 */
// Function
// - counter monitor register reads the live 8-bit up counter value.
// - counter overflow raising an interrupt sets status bit 2.
// - clear attempt outside the clear window while running sets status bit 1.
// - status bit 0 shows whether watchdog operation is enabled.
// - status read clears both cause flags; bits 7..3 read reset values.
// - setting run-enable starts counting; re-enable needs no code write.
// - run-enable becomes 1 when the post-reset warm-up ends.
// - disable needs run-enable cleared then disable code; disable zeroes counter.
// - disable code coinciding with overflow wins; no overflow detected.
// - source clock free-runs, so first overflow may come one tick early.
// - window code 00 accepts a clear at any time.
// - nonzero window: early clear while running raises interrupt, counter keeps counting.
// - overflow-time field picks one of four overflow periods.
// - overflow action bit selects reset or interrupt; interrupt mode keeps counting.
// - counter and prescaler pause during low-power modes and resume afterwards.
// - action bit 0 raises a non-maskable interrupt.
// - each new watchdog interrupt is signalled at once, even back to back.
// - action bit 1 raises a chip reset request.
// - clear code resets the up counter to zero; counting continues.
// - clear code coinciding with overflow wins; no overflow detected.
// - periods are 2^18..2^24 gear or 2^11..2^17 low clock cycles.
// - window, time and action fields locked while run-enable is 1; a control write with bit 0 set still changes them.
// - code port is write-only, reads zero; other codes have no effect.
package wdt_pkg;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CONTROL  = 12'hFD4;
	localparam logic [11:0] IDX_CODE     = 12'hFD5;
	localparam logic [11:0] IDX_COUNTER  = 12'hFD6;
	localparam logic [11:0] IDX_STATUS   = 12'hFD7;

	// control register fields
	localparam int          CTL_EN_BIT   = 0;
	localparam int          CTL_ACT_BIT  = 1;
	localparam int          CTL_TIME_LSB = 2;
	localparam int          CTL_WIN_LSB  = 4;
	localparam logic [1:0]  CTL_TOP_BITS = 2'h2;

	// status register fields
	localparam int          ST_RUN_BIT   = 0;
	localparam int          ST_EARLY_BIT = 1;
	localparam int          ST_OVF_BIT   = 2;
	localparam logic [7:0]  ST_RESET     = 8'h59;

	// control codes
	localparam logic [7:0]  CODE_CLEAR   = 8'h4E;
	localparam logic [7:0]  CODE_DISABLE = 8'hB1;

	// reset values
	localparam logic [7:0]  CNT_RESET    = 8'h00;
	localparam logic [1:0]  WIN_RESET    = 2'h0;
	localparam logic [1:0]  TIME_RESET   = 2'h0;
	localparam logic        ACT_RESET    = 1'b0;

	// clear window starts (counter value at which the window opens)
	localparam logic [7:0]  WIN_START_01 = 8'h80;
	localparam logic [7:0]  WIN_START_10 = 8'hC0;
	localparam logic [7:0]  WIN_START_11 = 8'hE0;
	localparam logic [7:0]  CNT_MAX      = 8'hFF;

	// prescale exponents: counter tick every 2^(base + step*code) source cycles
	localparam int          PRE_W         = 16;
	localparam logic [4:0]  PRE_GEAR_BASE = 5'h0A;
	localparam logic [4:0]  PRE_LOW_BASE  = 5'h03;
	localparam int          CNT_W         = 8;

	// warm-up after reset release, in system clock cycles
	localparam int          WARM_W        = 16;
	localparam int          WARMUP_CYCLES = 16;

	typedef enum logic [2:0] {
		PH_WARM = 3'b001,
		PH_ON   = 3'b010,
		PH_OFF  = 3'b100
	} wdt_phase_e;

endpackage : wdt_pkg

// ==== rtl/wdt_prescaler.sv ====
/*
 * wdt_prescaler: free-running divider that makes the up counter's source tick.
 * Assumes low_tick pulses once per low-frequency clock period, synchronous to sys_clk_i.
 */
module wdt_prescaler (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	wdt_tick_if.pre   tk
);

	typedef struct packed {
		logic [wdt_pkg::PRE_W-1:0] div;
	} wdt_pre_s;

	wdt_pre_s                  s_r;
	wdt_pre_s                  s_nxt;
	logic                      step;
	logic [4:0]                expo;
	logic [wdt_pkg::PRE_W:0]   mask_wide;
	logic [wdt_pkg::PRE_W-1:0] mask;

	always_comb begin
		step      = tk.run && (tk.use_low ? tk.low_tick : 1'b1);
		expo      = (tk.use_low ? wdt_pkg::PRE_LOW_BASE : wdt_pkg::PRE_GEAR_BASE)
		            + {2'h0, tk.time_sel, 1'b0};
		mask_wide = ({{wdt_pkg::PRE_W{1'b0}}, 1'b1} << expo) - 17'h00001;
		mask      = mask_wide[wdt_pkg::PRE_W-1:0];
		tk.tick   = step && ((s_r.div & mask) == mask);
		s_nxt     = s_r;
		if (step) begin
			// never cleared by the core: a free divider gives the early first tick
			s_nxt.div = s_r.div + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule : wdt_prescaler

// ==== rtl/wdt_tick_if.sv ====
/*
 * wdt_tick_if: carrier between the watchdog core and its source-clock prescaler.
 * Assumes both ends share the system clock; no clocking here.
 */
interface wdt_tick_if;
	logic       run;
	logic       use_low;
	logic       low_tick;
	logic [1:0] time_sel;
	logic       tick;

	modport core (output run, output use_low, output low_tick, output time_sel, input tick);
	modport pre  (input run, input use_low, input low_tick, input time_sel, output tick);
endinterface : wdt_tick_if

// ==== rtl/wdt_top.sv ====
/*
 * wdt_top: windowed watchdog with classic Wishbone register access.
 * Assumes the system clock is the gear clock, low_clk_tick_i is a one-cycle pulse per
 * low-frequency clock period, and the outside resets the chip on chip_rst_req_o.
 */
// Implementation choice: the Wishbone register port.
module wdt_top #(
	parameter int ADR_W         = 14,
	parameter int WARMUP_CYCLES = wdt_pkg::WARMUP_CYCLES
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        low_clk_tick_i,
	input  wire logic        base_prescale_select_i,
	input  wire logic        slow_mode_i,
	input  wire logic        low_power_i,
	output logic             nmi_req_o,
	output logic             chip_rst_req_o
);

	if (ADR_W < 14 || ADR_W > 32) begin : g_chk_adr
		$error("wdt_top: ADR_W must lie in 14..32");
	end
	if (WARMUP_CYCLES < 1 || WARMUP_CYCLES >= (1 << wdt_pkg::WARM_W)) begin : g_chk_warm
		$error("wdt_top: WARMUP_CYCLES out of range");
	end

	localparam logic [wdt_pkg::WARM_W-1:0] WARM_LAST = wdt_pkg::WARM_W'(WARMUP_CYCLES - 1);

	typedef struct packed {
		wdt_pkg::wdt_phase_e           phase;
		logic [wdt_pkg::WARM_W-1:0]    warm;
		logic [wdt_pkg::CNT_W-1:0]     cnt;
		logic                          ctl_en;
		logic                          ctl_act;
		logic [1:0]                    ctl_time;
		logic [1:0]                    ctl_win;
		logic                          flag_ovf;
		logic                          flag_early;
		logic                          ack;
		logic [7:0]                    dat;
		logic                          nmi;
		logic                          rst_req;
	} wdt_state_s;

	localparam wdt_state_s STATE_RESET = '{
		phase:      wdt_pkg::PH_WARM,
		warm:       '0,
		cnt:        wdt_pkg::CNT_RESET,
		ctl_en:     1'b0,
		ctl_act:    wdt_pkg::ACT_RESET,
		ctl_time:   wdt_pkg::TIME_RESET,
		ctl_win:    wdt_pkg::WIN_RESET,
		flag_ovf:   1'b0,
		flag_early: 1'b0,
		ack:        1'b0,
		dat:        8'h00,
		nmi:        1'b0,
		rst_req:    1'b0
	};

	// word index decode, used for every register
	function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [11:0] idx);
		logic [ADR_W-3:0] word;
		word    = adr[ADR_W-1:2];
		reg_hit = (word == (ADR_W-2)'(idx));
	endfunction : reg_hit

	// counter value at which the clear window opens
	function automatic logic [7:0] win_start(input logic [1:0] win);
		logic [7:0] start;
		unique case (win)
			2'h0: start = 8'h00;
			2'h1: start = wdt_pkg::WIN_START_01;
			2'h2: start = wdt_pkg::WIN_START_10;
			2'h3: start = wdt_pkg::WIN_START_11;
		endcase
		win_start = start;
	endfunction : win_start

	wdt_state_s s_r;
	wdt_state_s s_nxt;

	wdt_tick_if tk ();

	wdt_prescaler u_pre (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.tk        (tk.pre)
	);

	logic       req;
	logic       commit;
	logic       wr_ctl;
	logic       wr_code;
	logic       rd_status;
	logic [7:0] wbyte;
	logic [7:0] rd_val;
	logic       running;
	logic       cnt_go;
	logic       clr_code;
	logic       in_window;
	logic       clr_ok;
	logic       clr_early;
	logic       dis_ok;
	logic       ovf;
	logic       ctl_free;

	always_comb begin
		// source clock follows gear or low clock; prescaler and counter stop in low power
		tk.run      = !low_power_i;
		tk.use_low  = base_prescale_select_i || slow_mode_i;
		tk.low_tick = low_clk_tick_i;
		tk.time_sel = s_r.ctl_time;
	end

	always_comb begin
		s_nxt         = s_r;
		s_nxt.nmi     = 1'b0;
		s_nxt.rst_req = 1'b0;

		// decoded first: the status read mux below needs it in the same pass
		running = (s_r.phase == wdt_pkg::PH_ON);
		cnt_go  = running && tk.tick;

		// bus: request seen -> ack next cycle; write and read-clear act at the acked edge
		req       = wb_cyc_i && wb_stb_i;
		commit    = req && s_r.ack;
		s_nxt.ack = req && !s_r.ack;
		wbyte     = wb_dat_i[7:0];
		wr_ctl    = commit && wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, wdt_pkg::IDX_CONTROL);
		wr_code   = commit && wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, wdt_pkg::IDX_CODE);
		rd_status = commit && !wb_we_i && reg_hit(wb_adr_i, wdt_pkg::IDX_STATUS);

		// read mux; unmapped words and the code port read zero
		rd_val = 8'h00;
		if (reg_hit(wb_adr_i, wdt_pkg::IDX_CONTROL)) begin
			rd_val = {wdt_pkg::CTL_TOP_BITS, s_r.ctl_win, s_r.ctl_time, s_r.ctl_act, s_r.ctl_en};
		end else if (reg_hit(wb_adr_i, wdt_pkg::IDX_COUNTER)) begin
			rd_val = s_r.cnt;
		end else if (reg_hit(wb_adr_i, wdt_pkg::IDX_STATUS)) begin
			rd_val = {wdt_pkg::ST_RESET[7:3], s_r.flag_ovf, s_r.flag_early, running};
		end
		if (req && !s_r.ack && !wb_we_i) begin
			s_nxt.dat = rd_val;
		end

		// control codes
		clr_code  = wr_code && (wbyte == wdt_pkg::CODE_CLEAR);
		in_window = (s_r.ctl_win == 2'h0) || (s_r.cnt >= win_start(s_r.ctl_win));
		clr_ok    = clr_code && in_window;
		clr_early = clr_code && !in_window && running;
		dis_ok    = wr_code && (wbyte == wdt_pkg::CODE_DISABLE) && !s_r.ctl_en && running;
		ovf       = cnt_go && (s_r.cnt == wdt_pkg::CNT_MAX) && !clr_ok && !dis_ok;

		// phase sequencing
		unique case (s_r.phase)
			wdt_pkg::PH_WARM: begin
				s_nxt.warm = s_r.warm + 16'h0001;
				if (s_r.warm == WARM_LAST) begin
					s_nxt.phase  = wdt_pkg::PH_ON;
					s_nxt.ctl_en = 1'b1;
				end
			end
			wdt_pkg::PH_ON: begin
				if (dis_ok) begin
					s_nxt.phase = wdt_pkg::PH_OFF;
				end
			end
			wdt_pkg::PH_OFF: begin
				s_nxt.phase = wdt_pkg::PH_OFF;
			end
			default: begin
				s_nxt.phase = wdt_pkg::PH_OFF;
			end
		endcase

		// control register; fields locked while enabled unless this write enables
		ctl_free = !s_r.ctl_en || wbyte[wdt_pkg::CTL_EN_BIT];
		if (wr_ctl) begin
			s_nxt.ctl_en = wbyte[wdt_pkg::CTL_EN_BIT];
			if (ctl_free) begin
				s_nxt.ctl_act  = wbyte[wdt_pkg::CTL_ACT_BIT];
				s_nxt.ctl_time = wbyte[wdt_pkg::CTL_TIME_LSB +: 2];
				s_nxt.ctl_win  = wbyte[wdt_pkg::CTL_WIN_LSB +: 2];
			end
			// re-enable straight from disabled, no code needed
			if (wbyte[wdt_pkg::CTL_EN_BIT] && s_r.phase == wdt_pkg::PH_OFF) begin
				s_nxt.phase = wdt_pkg::PH_ON;
			end
			// the warm-up end forces run-enable on regardless
			if (s_r.phase == wdt_pkg::PH_WARM && s_r.warm == WARM_LAST) begin
				s_nxt.ctl_en = 1'b1;
			end
		end

		// up counter; 8-bit wrap keeps it counting after an interrupt-mode overflow
		if (dis_ok) begin
			s_nxt.cnt = wdt_pkg::CNT_RESET;
		end else if (clr_ok) begin
			s_nxt.cnt = wdt_pkg::CNT_RESET;
		end else if (cnt_go) begin
			s_nxt.cnt = s_r.cnt + 8'h01;
		end

		// read clears only the bits actually returned, so a set in flight is kept
		if (rd_status) begin
			s_nxt.flag_ovf   = s_r.flag_ovf && !s_r.dat[wdt_pkg::ST_OVF_BIT];
			s_nxt.flag_early = s_r.flag_early && !s_r.dat[wdt_pkg::ST_EARLY_BIT];
		end

		// overflow action
		if (ovf) begin
			if (s_r.ctl_act) begin
				s_nxt.rst_req = 1'b1;
			end else begin
				s_nxt.nmi      = 1'b1;
				s_nxt.flag_ovf = 1'b1;
			end
		end
		if (clr_early) begin
			s_nxt.nmi        = 1'b1;
			s_nxt.flag_early = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_r <= STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_o       = s_r.ack;
	assign wb_dat_o       = {24'h000000, s_r.dat};
	assign nmi_req_o      = s_r.nmi;
	assign chip_rst_req_o = s_r.rst_req;

endmodule : wdt_top
